/* File: midrange_size_and_peripheral_mode_pkg.sv */
// Package: constants and types for the mid-range and peripheral chip-select decoder
package midrange_size_and_peripheral_mode_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_PERIPH_BASE = 8'ha4;
  localparam logic [7:0] MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_MID_BASE    = 8'ha6;
  localparam logic [7:0] MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_SIZE_MODE   = 8'ha8;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SIZE_LSB    = 8;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SIZE_W      = 7;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_EXTRA_BIT   = 7;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SPACE_BIT   = 6;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_BASE_LSB = 9;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PBA_LSB     = 6;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_RDY_W       = 3;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_ADDR_W      = 20;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_NUM_MID     = 4;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_NUM_PER     = 7;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_MIN_LOG = 13;   // 8K total block
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_WIN_LOG = 7;    // 128-byte windows
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_BLK_LOG = 10;   // 1K base alignment
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_IO_ADDR_W   = 16;
  localparam int MIDRANGE_SIZE_AND_PERIPHERAL_MODE_ENH_MID_IDX = 2;

  // Reset values of the outputs
  localparam logic [3:0] MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_IDLE = 4'hf;
  localparam logic [6:0] MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_IDLE = 7'h7f;
  localparam logic [2:0] MIDRANGE_SIZE_AND_PERIPHERAL_MODE_RDY_RST  = 3'h0;

  // Bus cycle as seen by the decoder
  typedef struct packed {
    logic        valid;
    logic        is_mem;
    logic        from_dma;
    logic [19:0] addr;
  } midrange_size_and_peripheral_mode_cycle_t;

  // Register write/access port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  ofs;
    logic [15:0] wdata;
  } midrange_size_and_peripheral_mode_regacc_t;

  // Ready information handed to the wait-state generator
  typedef struct packed {
    logic       hit;
    logic [1:0] waits;
    logic       ignore_ext;
  } midrange_size_and_peripheral_mode_ready_t;

endpackage

/* File: midrange_size_and_peripheral_mode_chip_select.sv */
// Mid-range memory and peripheral chip-select decoder
`timescale 1ns/1ps
module midrange_size_and_peripheral_mode_chip_select (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  // Mode
  input  wire logic                  enhanced_mode,
  // Register access from the control block
  input  wire midrange_size_and_peripheral_mode_pkg::midrange_size_and_peripheral_mode_regacc_t reg_acc,
  output logic [15:0]                reg_rdata,
  // Current CPU or DMA bus cycle
  input  wire midrange_size_and_peripheral_mode_pkg::midrange_size_and_peripheral_mode_cycle_t  cyc,
  // Chip selects, active low
  output logic [3:0]                 midrange_select_n,
  output logic [6:0]                 peripheral_select_n,
  // Latched address bits when extra selects are off
  output logic                       latched_a1,
  output logic                       latched_a2,
  // Ready mode toward the wait-state generator
  output midrange_size_and_peripheral_mode_pkg::midrange_size_and_peripheral_mode_ready_t      ready_info
);
  import midrange_size_and_peripheral_mode_pkg::*;

  // ---------------------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------------------
  logic [15:0] periph_base_ff, nxt_periph_base;
  logic [15:0] mid_base_ff,    nxt_mid_base;
  logic [15:0] size_mode_ff,   nxt_size_mode;
  logic        acc_pb_ff,  nxt_acc_pb;
  logic        acc_mb_ff,  nxt_acc_mb;
  logic        acc_sz_ff,  nxt_acc_sz;
  logic [15:0] rdata_ff,   nxt_rdata;

  // Register writes and access tracking; a read also counts as access
  always_comb begin
    nxt_periph_base = periph_base_ff;
    nxt_mid_base    = mid_base_ff;
    nxt_size_mode   = size_mode_ff;
    nxt_acc_pb      = acc_pb_ff;
    nxt_acc_mb      = acc_mb_ff;
    nxt_acc_sz      = acc_sz_ff;
    nxt_rdata       = rdata_ff;
    if (reg_acc.wr || reg_acc.rd) begin
      case (reg_acc.ofs)
        MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_PERIPH_BASE: begin
          nxt_acc_pb = 1'b1;
          if (reg_acc.wr) begin
            nxt_periph_base = reg_acc.wdata;
          end
        end
        MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_MID_BASE: begin
          nxt_acc_mb = 1'b1;
          if (reg_acc.wr) begin
            nxt_mid_base = reg_acc.wdata;
          end
        end
        MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_SIZE_MODE: begin
          nxt_acc_sz = 1'b1;
          if (reg_acc.wr) begin
            nxt_size_mode = reg_acc.wdata;
          end
        end
        default: begin
        end
      endcase
    end
    if (reg_acc.rd) begin
      case (reg_acc.ofs)
        MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_PERIPH_BASE: nxt_rdata = periph_base_ff;
        MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_MID_BASE:    nxt_rdata = mid_base_ff;
        MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_SIZE_MODE:   nxt_rdata = size_mode_ff;
        default:              nxt_rdata = 16'h0000;
      endcase
    end
  end

  // Register update; contents are undefined after reset, so only the access flags and read data clear
  always_ff @(posedge clk_sys) begin
    periph_base_ff <= nxt_periph_base;
    mid_base_ff    <= nxt_mid_base;
    size_mode_ff   <= nxt_size_mode;
    if (srst) begin
      acc_pb_ff <= 1'b0;
      acc_mb_ff <= 1'b0;
      acc_sz_ff <= 1'b0;
      rdata_ff  <= 16'h0000;
    end else begin
      acc_pb_ff <= nxt_acc_pb;
      acc_mb_ff <= nxt_acc_mb;
      acc_sz_ff <= nxt_acc_sz;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ---------------------------------------------------------------------------
  // Mid-range decode
  // ---------------------------------------------------------------------------
  logic [MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SIZE_W-1:0] size_onehot;
  logic [19:0]            mid_base_addr;
  logic [19:0]            mid_mask;
  logic [1:0]             mid_quarter;
  logic                   mid_hit;
  logic [3:0]             nxt_mid_sel_n;

  assign size_onehot   = size_mode_ff[MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SIZE_LSB +: MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SIZE_W];
  assign mid_base_addr = {mid_base_ff[15:MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_BASE_LSB], 13'h0000};

  // Block mask and quarter index from the one-hot size field
  always_comb begin
    mid_mask    = 20'h00000;
    mid_quarter = 2'h0;
    for (int i = 0; i < MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SIZE_W; i++) begin
      if (size_onehot[i]) begin
        mid_mask    = 20'hfffff << (MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_MIN_LOG + i);
        mid_quarter = 2'(cyc.addr >> (MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_MIN_LOG - 2 + i));
      end
    end
  end

  // Only the block-aligned bits are compared, so software must align the base
  assign mid_hit = cyc.valid && cyc.is_mem && acc_mb_ff && acc_sz_ff &&
                   (|size_onehot) &&
                   ((cyc.addr & mid_mask) == (mid_base_addr & mid_mask));

  // One select low per quarter; enhanced mode keeps only select 2
  always_comb begin
    nxt_mid_sel_n = MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_IDLE;
    if (mid_hit) begin
      nxt_mid_sel_n[mid_quarter] = 1'b0;
    end
    if (enhanced_mode) begin
      for (int i = 0; i < MIDRANGE_SIZE_AND_PERIPHERAL_MODE_NUM_MID; i++) begin
        if (i != MIDRANGE_SIZE_AND_PERIPHERAL_MODE_ENH_MID_IDX) begin
          nxt_mid_sel_n[i] = 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Peripheral decode
  // ---------------------------------------------------------------------------
  logic [19:0] peripheral_base_address;
  logic        space_ok;
  logic        per_enabled;
  logic [6:0]  per_hit;
  logic [6:0]  nxt_per_sel_n;
  logic        extra_selects_enable;
  logic        peripheral_space_is_memory;
  logic        nxt_a1;
  logic        nxt_a2;

  assign extra_selects_enable       = size_mode_ff[MIDRANGE_SIZE_AND_PERIPHERAL_MODE_EXTRA_BIT];
  assign peripheral_space_is_memory = size_mode_ff[MIDRANGE_SIZE_AND_PERIPHERAL_MODE_SPACE_BIT];
  assign peripheral_base_address         = {periph_base_ff[15:MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PBA_LSB], 10'h000};
  assign space_ok    = (cyc.is_mem == peripheral_space_is_memory);
  assign per_enabled = cyc.valid && space_ok && acc_pb_ff && acc_sz_ff;

  // Seven 128-byte windows above the base
  genvar gp;
  generate
    for (gp = 0; gp < MIDRANGE_SIZE_AND_PERIPHERAL_MODE_NUM_PER; gp++) begin : g_per
      assign per_hit[gp] = per_enabled &&
        (cyc.addr[19:MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_BLK_LOG] == peripheral_base_address[19:MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_BLK_LOG]) &&
        (cyc.addr[MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_BLK_LOG-1:MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_WIN_LOG] == 3'(gp));
    end
  endgenerate

  // Selects 5 and 6 only when extra selects are enabled
  always_comb begin
    nxt_per_sel_n = ~per_hit;
    if (!extra_selects_enable) begin
      nxt_per_sel_n[6:5] = 2'b11;
    end
  end

  // Latched address bits follow each valid cycle
  assign nxt_a1 = cyc.valid ? cyc.addr[1] : latched_a1;
  assign nxt_a2 = cyc.valid ? cyc.addr[2] : latched_a2;

  // ---------------------------------------------------------------------------
  // Ready mode selection
  // ---------------------------------------------------------------------------
  logic [2:0]  nxt_code;
  logic        nxt_rdy_hit;
  midrange_size_and_peripheral_mode_ready_t nxt_ready;

  // Pick the ready code of whichever range is hit
  always_comb begin
    nxt_code    = MIDRANGE_SIZE_AND_PERIPHERAL_MODE_RDY_RST;
    nxt_rdy_hit = 1'b0;
    if (!nxt_mid_sel_n[0] || !nxt_mid_sel_n[1] || !nxt_mid_sel_n[2] || !nxt_mid_sel_n[3]) begin
      nxt_code    = mid_base_ff[MIDRANGE_SIZE_AND_PERIPHERAL_MODE_RDY_W-1:0];
      nxt_rdy_hit = 1'b1;
    end else if (|per_hit[3:0]) begin
      nxt_code    = periph_base_ff[MIDRANGE_SIZE_AND_PERIPHERAL_MODE_RDY_W-1:0];
      nxt_rdy_hit = 1'b1;
    end else if (!(&nxt_per_sel_n[6:4])) begin
      nxt_code    = size_mode_ff[MIDRANGE_SIZE_AND_PERIPHERAL_MODE_RDY_W-1:0];
      nxt_rdy_hit = 1'b1;
    end
    nxt_ready.hit        = nxt_rdy_hit;
    nxt_ready.waits      = nxt_code[1:0];
    nxt_ready.ignore_ext = nxt_code[2];
  end

  // ---------------------------------------------------------------------------
  // Output registers; all selects high in reset
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      midrange_select_n   <= MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_IDLE;
      peripheral_select_n <= MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_IDLE;
      latched_a1          <= 1'b0;
      latched_a2          <= 1'b0;
      ready_info          <= '0;
    end else begin
      midrange_select_n   <= nxt_mid_sel_n;
      peripheral_select_n <= nxt_per_sel_n;
      latched_a1          <= nxt_a1;
      latched_a2          <= nxt_a2;
      ready_info          <= nxt_ready;
    end
  end

endmodule

/* File: midrange_size_and_peripheral_mode_chip_select_properties.sv */
// Port-level assertions for the chip-select decoder
`timescale 1ns/1ps
module midrange_size_and_peripheral_mode_chip_select_properties (
  // Clock and reset
  input wire logic                   clk_sys,
  input wire logic                   srst,
  // Inputs
  input wire logic                   enhanced_mode,
  input wire midrange_size_and_peripheral_mode_pkg::midrange_size_and_peripheral_mode_regacc_t reg_acc,
  input wire midrange_size_and_peripheral_mode_pkg::midrange_size_and_peripheral_mode_cycle_t  cyc,
  // Outputs
  input wire logic [15:0]            reg_rdata,
  input wire logic [3:0]             midrange_select_n,
  input wire logic [6:0]             peripheral_select_n,
  input wire logic                   latched_a1,
  input wire logic                   latched_a2,
  input wire midrange_size_and_peripheral_mode_pkg::midrange_size_and_peripheral_mode_ready_t  ready_info
);
  import midrange_size_and_peripheral_mode_pkg::*;
  logic [2:0] seen_ff;
  logic [2:0] nxt_seen;
  logic       acc;
  logic       mi;
  logic       pi;
  // Offsets a8, a6, a4 touched since reset
  always_comb begin
    acc = reg_acc.wr | reg_acc.rd;
    mi = midrange_select_n == MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_IDLE;
    pi = peripheral_select_n == MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_IDLE;
    nxt_seen = srst ? 3'h0 : seen_ff | {acc && reg_acc.ofs == MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_SIZE_MODE,
      acc && reg_acc.ofs == MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_MID_BASE, acc && reg_acc.ofs == MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_PERIPH_BASE};
  end
  always_ff @(posedge clk_sys) begin
    seen_ff <= nxt_seen;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_RST_IDLE: assert property (disable iff (1'b0) srst |=> mi && pi)
    else $error("select active after reset");
  AST_MID_ONE: assert property ($onehot0(~midrange_select_n)) else $error("two mid selects");
  AST_PER_ONE: assert property ($onehot0(~peripheral_select_n)) else $error("two selects");
  AST_NO_CYC: assert property (!cyc.valid |=> mi && pi) else $error("select without cycle");
  AST_MID_ACC: assert property (!(seen_ff[1] && seen_ff[2]) |-> mi) else $error("mid early");
  AST_PER_ACC: assert property (!(seen_ff[0] && seen_ff[2]) |-> pi) else $error("per early");
  AST_ENH: assert property (enhanced_mode |=> (midrange_select_n | 4'h4) == 4'hf)
    else $error("handshake pin used as select");
  AST_A_LATCH: assert property (cyc.valid |=> {latched_a2, latched_a1} == $past(cyc.addr[2:1]))
    else $error("latched address wrong");
  AST_RDY_HIT: assert property (!(mi && pi) |-> ready_info.hit) else $error("ready not hit");
  // Main scenarios reached
  COV_MID: cover property (!mi);
  COV_PER: cover property (!peripheral_select_n[6]);
  COV_ENH: cover property (enhanced_mode ##1 !midrange_select_n[2]);
endmodule
bind midrange_size_and_peripheral_mode_chip_select midrange_size_and_peripheral_mode_chip_select_properties u_props (.clk_sys(clk_sys), .srst(srst),
  .enhanced_mode(enhanced_mode), .reg_acc(reg_acc), .cyc(cyc), .reg_rdata(reg_rdata),
  .midrange_select_n(midrange_select_n), .peripheral_select_n(peripheral_select_n),
  .latched_a1(latched_a1), .latched_a2(latched_a2), .ready_info(ready_info));

/* File: midrange_size_and_peripheral_mode_ext_chips.sv */
// Behavioural model of the memory banks and peripheral chips
`timescale 1ns/1ps
module midrange_size_and_peripheral_mode_ext_chips (
  // Selects from the decoder
  input wire logic       clk_sys,
  input wire logic [3:0] midrange_select_n,
  input wire logic [6:0] peripheral_select_n,
  // Chips enabled in the previous cycle
  output logic [3:0]     n_enabled
);
  // Every chip whose select is low counts itself
  always_ff @(posedge clk_sys) begin
    n_enabled <= 4'd11 - 4'($countones({midrange_select_n, peripheral_select_n}));
  end
endmodule

/* File: testbench.sv */
// Self-checking testbench for the chip-select decoder
`timescale 1ns/1ps
module testbench;
  import midrange_size_and_peripheral_mode_pkg::*;
  typedef struct packed {
    logic [3:0] mid;
    logic [6:0] per;
    logic [1:0] a21;
    logic [1:0] rm;  // 0 no hit, 1 full ready compare, 2 skip
    midrange_size_and_peripheral_mode_ready_t rdy;
  } midrange_size_and_peripheral_mode_exp_t;
  logic         clk_sys = 1'b0;
  logic         srst = 1'b1;
  logic         enhanced_mode = 1'b0;
  midrange_size_and_peripheral_mode_regacc_t reg_acc = '0;
  midrange_size_and_peripheral_mode_cycle_t  cyc = '0;
  logic [15:0]  reg_rdata;
  logic [3:0]   midrange_select_n;
  logic [6:0]   peripheral_select_n;
  logic         latched_a1;
  logic         latched_a2;
  midrange_size_and_peripheral_mode_ready_t  ready_info;
  logic [3:0]   n_enabled;
  logic [15:0]  rg [3];
  logic [2:0]   seen = 3'h0;
  logic [1:0]   last_a = 2'h0;
  midrange_size_and_peripheral_mode_exp_t    q [$];
  midrange_size_and_peripheral_mode_exp_t    me;
  int           n_mismatch = 0;
  int           tests_run = 0;
  integer       seed = 32'h7629;
  always #12.5 clk_sys = ~clk_sys;
  midrange_size_and_peripheral_mode_chip_select DUT (.clk_sys(clk_sys), .srst(srst), .enhanced_mode(enhanced_mode),
    .reg_acc(reg_acc), .reg_rdata(reg_rdata), .cyc(cyc), .midrange_select_n(midrange_select_n),
    .peripheral_select_n(peripheral_select_n), .latched_a1(latched_a1),
    .latched_a2(latched_a2), .ready_info(ready_info));
  midrange_size_and_peripheral_mode_ext_chips u_chips (.clk_sys(clk_sys), .midrange_select_n(midrange_select_n),
    .peripheral_select_n(peripheral_select_n), .n_enabled(n_enabled));
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Register write or read, read data checked a cycle later
  task automatic reg_op(input logic wr, input logic [7:0] ofs, input logic [15:0] d);
    logic ok;
    ok = ofs inside {MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_PERIPH_BASE, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_MID_BASE, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_SIZE_MODE};
    @(negedge clk_sys);
    reg_acc <= '{wr, ~wr, ofs, d};
    if (ok) seen[2'((ofs - 8'ha4) >> 1)] = 1'b1;
    if (ok && wr) rg[2'((ofs - 8'ha4) >> 1)] = d;
    @(negedge clk_sys);
    reg_acc <= '0;
    if (!wr) check(reg_rdata, ok ? rg[2'((ofs - 8'ha4) >> 1)] : 16'h0000);
  endtask
  // Expected outputs for one bus cycle
  function automatic midrange_size_and_peripheral_mode_exp_t expect_of(input midrange_size_and_peripheral_mode_cycle_t c, input logic enh);
    midrange_size_and_peripheral_mode_exp_t   e;
    logic [19:0] msk;
    logic [19:0] off;
    logic [2:0]  code;
    int          k;
    e = '0;
    e.mid = MIDRANGE_SIZE_AND_PERIPHERAL_MODE_MID_IDLE;
    e.per = MIDRANGE_SIZE_AND_PERIPHERAL_MODE_PER_IDLE;
    e.a21 = c.valid ? c.addr[2:1] : last_a;
    k = 0;
    for (int i = 0; i < 7; i++)
      if (rg[2][8 + i]) k = i;
    msk = 20'hfffff << (13 + k);
    if (c.valid && c.is_mem && seen[1] && seen[2] && (c.addr & msk) == ({rg[1][15:9], 13'h0} & msk)) begin
      e.mid[2'((c.addr & ~msk) >> (11 + k))] = 1'b0;
      e.rdy = {1'b1, rg[1][1:0], rg[1][2]};
      e.rm = (enh && e.mid[2]) ? 2'd2 : 2'd1;
      if (enh) e.mid = e.mid | 4'hb;
    end
    off = c.addr - {rg[0][15:6], 10'h0};
    code = off < 20'd512 ? rg[0][2:0] : rg[2][2:0];
    if (c.valid && c.is_mem == rg[2][6] && seen[0] && seen[2] && off < 20'd896) begin
      if (off < 20'd640 || rg[2][7]) begin
        e.per[3'(off >> 7)] = 1'b0;
        if (e.rm == 2'd0) e.rdy = {1'b1, code[1:0], code[2]};
        if (e.rm == 2'd0) e.rm = 2'd1;
      end else e.rm = 2'd2;
    end
    return e;
  endfunction
  // Drive one cycle and note its expected result
  task automatic cyc_op(input midrange_size_and_peripheral_mode_cycle_t c, input logic enh);
    @(negedge clk_sys);
    cyc <= c;
    enhanced_mode <= enh;
    q.push_back(expect_of(c, enh));
    if (c.valid) last_a = c.addr[2:1];
  endtask
  // Random cycles aimed at the mid block, the peripheral block or anywhere
  task automatic burst(input int n);
    midrange_size_and_peripheral_mode_cycle_t c;
    logic [31:0] r;
    logic [31:0] s;
    for (int i = 0; i < n; i++) begin
      r = $random(seed);
      s = $random(seed);
      c.valid = r[0] | r[1];
      c.from_dma = r[2];
      c.addr = r[6:5] == 2'd0 ? {rg[1][15:9], s[12:0]} + (20'(s[18:13]) << 13) :
               r[6:5] == 2'd1 ? {rg[0][15:6], s[9:0]} : s[19:0];
      c.is_mem = r[6:5] == 2'd1 ? rg[2][6] ^ (r[4:3] == 2'd0) : r[4:3] != 2'd0;
      if (!c.is_mem) c.addr[19:16] = 4'h0;
      cyc_op(c, r[8:7] == 2'd0);
    end
    cyc_op('0, 1'b0);
  endtask
  // New settings; software keeps alignment, 512K at zero, I/O base below 64K
  task automatic configure();
    logic [31:0] r;
    int          k;
    r = $random(seed);
    k = int'(r[31:28]) % 7;
    reg_op(1'b1, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_MID_BASE, {1'b0, r[5:0] & (6'h3f << k), 6'h0, r[8:6]});
    burst(4);
    reg_op(1'b1, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_SIZE_MODE, {1'b0, 7'h1 << k, r[9], r[10], r[13:8]});
    burst(4);
    reg_op(1'b1, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_PERIPH_BASE, {r[10] ? 4'hf : 4'h0, r[23:18], r[29:24]});
    burst(12);
  endtask
  // Outputs compared a cycle after each noted cycle
  always begin
    @(posedge clk_sys);
    if (q.size() > 0) begin
      me = q.pop_front();
      @(negedge clk_sys);
      check(midrange_select_n, me.mid);
      check(peripheral_select_n, me.per);
      check({latched_a2, latched_a1}, me.a21);
      if (me.rm == 2'd0) check(ready_info.hit, 1'b0);
      if (me.rm == 2'd1) check(ready_info, me.rdy);
      check(n_enabled > 4'h1, 1'b0);
    end
  end
  initial begin
    #(25 * 30000);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (3) @(negedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 40; i++) configure();
    reg_op(1'b0, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_MID_BASE, 16'h0000);
    reg_op(1'b0, 8'haa, 16'h0000);
    @(negedge clk_sys);
    srst <= 1'b1;
    seen = 3'h0;
    last_a = 2'h0;
    @(negedge clk_sys);
    srst <= 1'b0;
    burst(8);
    reg_op(1'b0, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_PERIPH_BASE, 16'h0000);
    reg_op(1'b0, MIDRANGE_SIZE_AND_PERIPHERAL_MODE_OFS_SIZE_MODE, 16'h0000);
    burst(16);
    conclude();
  end
endmodule
